//--- rtl/amp_port.sv
// async external memory port pin logic
`timescale 1ns/1ps
module amp_port
	import amp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_cond,
	input wire logic req_boot,
	input wire logic [amp_pkg::ADDR_W-1:0] req_addr,
	input wire logic [amp_pkg::DATA_W-1:0] req_wdata,
	input wire logic [1:0] addr_func,
	input wire logic [1:0] data_func,
	input wire logic [1:0] flag_bank_en,
	input wire logic [amp_pkg::DATA_W-1:0] data_alt_out,
	input wire logic [3:0] flag_out,
	input wire logic [3:0] flag_dir,
	input wire logic wait_acknowledge,
	input wire logic [amp_pkg::ADDR_W-1:0] ext_addr_bus_in,
	input wire logic [amp_pkg::DATA_W-1:0] ext_data_bus_in,
	input wire logic [3:0] flag_in,
	output logic req_ready,
	output logic rsp_valid,
	output logic [amp_pkg::DATA_W-1:0] rsp_rdata,
	output logic [amp_pkg::ADDR_W-1:0] parallel_data_input,
	output logic [amp_pkg::DATA_W-1:0] data_alt_in,
	output logic [3:0] flag_level,
	output logic [amp_pkg::ADDR_W-1:0] ext_addr_bus_out,
	output logic ext_addr_bus_oe_n,
	output logic [amp_pkg::DATA_W-1:0] ext_data_bus_out,
	output logic ext_data_bus_oe_n,
	output logic [1:0] bank_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic [3:0] flag_pin_out,
	output logic [3:0] flag_pin_oe_n
);
	import amp_pkg::*;

	// ************************************************
	// decode helpers
	// ************************************************
	function automatic logic [BANK_W-1:0] bank_decode(
		input logic [ADDR_W-1:0] a, input logic boot);
		logic [BANK_W-1:0] sel;
		sel = BANK_IDLE;
		sel[a[ADDR_W-1:BANK_LSB]] = 1'b0;
		// boot fetches always go to the flash on bank 1
		if (boot)
			sel = 4'hD;
		return sel;
	endfunction

	// ************************************************
	// synchronised pin inputs
	// ************************************************
	amp_sync_if #(.W(1)) ack_if ();
	amp_sync_if #(.W(ADDR_W)) adr_if ();
	amp_sync_if #(.W(DATA_W)) dat_if ();
	amp_sync_if #(.W(4)) flg_if ();
	assign ack_if.raw = wait_acknowledge;
	assign adr_if.raw = ext_addr_bus_in;
	assign dat_if.raw = ext_data_bus_in;
	assign flg_if.raw = flag_in;
	amp_sync #(.W(1), .INIT(1'b1)) u_ack (.ref_clk(ref_clk), .rst(rst),
		.s(ack_if));
	amp_sync #(.W(ADDR_W)) u_adr (.ref_clk(ref_clk), .rst(rst),
		.s(adr_if));
	amp_sync #(.W(DATA_W)) u_dat (.ref_clk(ref_clk), .rst(rst),
		.s(dat_if));
	amp_sync #(.W(4), .INIT(4'hF)) u_flg (.ref_clk(ref_clk), .rst(rst),
		.s(flg_if));

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		amp_state_e st;
		logic [3:0] cnt;
		logic [2:0] lag;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic addr_oe_n;
		logic [DATA_W-1:0] dout;
		logic dout_oe_n;
		logic [BANK_W-1:0] bank;
		logic rd_n;
		logic wr_n;
		logic ready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [ADDR_W-1:0] pdi;
		logic [DATA_W-1:0] dalt;
		logic [3:0] flv;
		logic [3:0] fout;
		logic [3:0] foe_n;
	} amp_port_s;
	amp_port_s st_q;
	amp_port_s st_d;

	always_comb
	begin
		st_d = st_q;
		st_d.rvalid = 1'b0;
		st_d.cnt = (st_q.cnt != 4'h0) ? st_q.cnt - 4'h1 : 4'h0;
		st_d.lag = (st_q.lag != 3'h0) ? st_q.lag - 3'h1 : 3'h0;
		case (st_q.st)
			AMP_IDLE:
			begin
				if (req_valid && st_q.ready && !req_cond)
					st_d.rvalid = 1'b1;
				else if (req_valid && st_q.ready)
				begin
					st_d.st = AMP_STROBE;
					st_d.ready = 1'b0;
					st_d.wr = req_write;
					st_d.cnt = STROBE_CYC;
					st_d.lag = ACK_LAG;
					st_d.addr = req_addr;
					st_d.bank = bank_decode(req_addr, req_boot);
					st_d.rd_n = req_write;
					st_d.wr_n = !req_write;
					st_d.dout = req_wdata;
					st_d.dout_oe_n = !(req_write &&
						data_func == FUNC_EXT);
				end
			end
			AMP_STROBE:
			begin
				if (st_q.cnt == 4'h1)
					st_d.st = AMP_WAIT;
			end
			AMP_WAIT:
			begin
				// hold while acknowledge low
				// the synchronised level trails the pin, so wait it out
				if (ack_if.level[0] && st_q.lag == 3'h0)
				begin
					st_d.st = AMP_DONE;
					st_d.rdata = dat_if.level;
				end
			end
			AMP_DONE:
			begin
				st_d.st = AMP_IDLE;
				st_d.bank = BANK_IDLE;
				st_d.rd_n = 1'b1;
				st_d.wr_n = 1'b1;
				st_d.dout_oe_n = 1'b1;
				st_d.rvalid = 1'b1;
				st_d.ready = 1'b1;
			end
			default:
				st_d.st = AMP_IDLE;
		endcase
		st_d.addr_oe_n = (addr_func == FUNC_PDI);
		st_d.pdi = adr_if.level;
		st_d.dalt = dat_if.level;
		if (data_func == FUNC_PWM || data_func == FUNC_FLAG)
		begin
			st_d.dout = data_alt_out;
			st_d.dout_oe_n = 1'b0;
		end
		else if (data_func == FUNC_PDI)
			st_d.dout_oe_n = 1'b1;
		else
			// memory mode drives data only during a write
			st_d.dout_oe_n = st_d.wr_n;
		st_d.flv = flg_if.level;
		for (int i = 0; i < 4; i++)
		begin
			st_d.fout[i] = flag_out[i];
			st_d.foe_n[i] = !flag_dir[i];
			if (i >= 2 && flag_bank_en[i[0]])
			begin
				st_d.fout[i] = st_d.bank[i];
				st_d.foe_n[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		// reset to memory and flag modes
		if (rst)
		begin
			st_q <= '0;
			st_q.st <= AMP_IDLE;
			st_q.bank <= BANK_IDLE;
			st_q.rd_n <= 1'b1;
			st_q.wr_n <= 1'b1;
			st_q.dout_oe_n <= 1'b1;
			st_q.foe_n <= 4'hF;
			st_q.ready <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	assign req_ready = st_q.ready;
	assign rsp_valid = st_q.rvalid;
	assign rsp_rdata = st_q.rdata;
	assign parallel_data_input = st_q.pdi;
	assign data_alt_in = st_q.dalt;
	assign flag_level = st_q.flv;
	assign ext_addr_bus_out = st_q.addr;
	assign ext_addr_bus_oe_n = st_q.addr_oe_n;
	assign ext_data_bus_out = st_q.dout;
	assign ext_data_bus_oe_n = st_q.dout_oe_n;
	assign bank_select_n = st_q.bank[1:0];
	assign read_strobe_n = st_q.rd_n;
	assign write_strobe_n = st_q.wr_n;
	assign flag_pin_out = st_q.fout;
	assign flag_pin_oe_n = st_q.foe_n;

	// ************************************************
	// checks
	// ************************************************
	sequence s_in_wait;
		st_q.st == AMP_WAIT && !ack_if.level[0];
	endsequence
	a_wait_holds: assert property (@(posedge ref_clk) disable iff (rst)
		s_in_wait |=> st_q.st == AMP_WAIT)
		else $error("access ended while acknowledge low");
	a_ack_settle: assert property (@(posedge ref_clk) disable iff (rst)
		st_q.st == AMP_WAIT && st_q.lag != 3'h0 |=> st_q.st == AMP_WAIT)
		else $error("access ended before acknowledge settled");
	a_strobe_excl: assert property (@(posedge ref_clk) disable iff (rst)
		!(read_strobe_n == 1'b0 && write_strobe_n == 1'b0))
		else $error("read and write strobes together");
	a_one_bank: assert property (@(posedge ref_clk) disable iff (rst)
		$countones(~st_q.bank) <= 1)
		else $error("more than one bank selected");
	a_idle_banks: assert property (@(posedge ref_clk) disable iff (rst)
		st_q.st == AMP_IDLE |-> bank_select_n == 2'h3)
		else $error("bank select active while idle");
	a_cond_false: assert property (@(posedge ref_clk) disable iff (rst)
		st_q.st == AMP_IDLE && req_valid && !req_cond |=>
		bank_select_n == 2'h3 && rsp_valid)
		else $error("false conditional access selected bank");
	a_read_strobe: assert property (@(posedge ref_clk) disable iff (rst)
		st_q.st == AMP_IDLE && req_valid && req_cond && !req_write |=>
		!read_strobe_n && write_strobe_n)
		else $error("read strobe missing");
	a_write_strobe: assert property (@(posedge ref_clk) disable iff (rst)
		st_q.st == AMP_IDLE && req_valid && req_cond && req_write |=>
		!write_strobe_n && ext_addr_bus_out == $past(req_addr))
		else $error("write strobe or address missing");
	a_boot_flash: assert property (@(posedge ref_clk) disable iff (rst)
		st_q.st == AMP_IDLE && req_valid && req_cond && req_boot |=>
		bank_select_n == 2'h1)
		else $error("boot fetch not on bank 1");
	a_pdi_float: assert property (@(posedge ref_clk) disable iff (rst)
		addr_func == FUNC_PDI |=> ext_addr_bus_oe_n)
		else $error("address driven in parallel input mode");
endmodule

//--- include/amp_pkg.sv
// package of constants and types for the async memory port pins
package amp_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 8;
	localparam int BANK_W = 4;
	// bank decode uses the top two address bits
	localparam int BANK_LSB = 22;
	localparam logic [BANK_W-1:0] BANK_IDLE = 4'hF;
	// strobe length before wait acknowledge is honoured
	localparam int STROBE_NS = 40;
	localparam int CLK_NS = 20;
	localparam logic [3:0] STROBE_CYC =
		4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	// edges before the synchronised acknowledge reflects a new strobe
	localparam logic [2:0] ACK_LAG = 3'h4;
	localparam logic [1:0] FUNC_EXT = 2'h0;
	localparam logic [1:0] FUNC_PDI = 2'h1;
	localparam logic [1:0] FUNC_FLAG = 2'h2;
	localparam logic [1:0] FUNC_PWM = 2'h3;
	typedef enum {AMP_IDLE, AMP_STROBE, AMP_WAIT, AMP_DONE} amp_state_e;
endpackage

//--- include/amp_sync_if.sv
// interface carrying synchronised pin inputs between modules
`timescale 1ns/1ps
interface amp_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] level;
	modport sync (input raw, output level);
	modport user (output raw, input level);
endinterface

//--- rtl/amp_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module amp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
)(
	input wire logic ref_clk,
	input wire logic rst,
	amp_sync_if.sync s
);
	typedef struct packed {
		logic [W-1:0] m1;
		logic [W-1:0] m2;
		logic [W-1:0] m3;
		logic [W-1:0] lvl;
	} amp_sync_s;
	amp_sync_s st_q;
	amp_sync_s st_d;
	always_comb
	begin
		st_d = st_q;
		st_d.m1 = s.raw;
		st_d.m2 = st_q.m1;
		st_d.m3 = st_q.m2;
		for (int i = 0; i < W; i++)
		begin
			if (st_q.m2[i] == st_q.m3[i])
				st_d.lvl[i] = st_q.m3[i];
		end
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			st_q <= {INIT, INIT, INIT, INIT};
		else
			st_q <= st_d;
	end
	assign s.level = st_q.lvl;
endmodule

//--- sim/amp_mem_model.sv
// behavioural external memory answering the port strobes
`timescale 1ns/1ps
module amp_mem_model (
	input wire logic ref_clk,
	input wire logic [amp_pkg::ADDR_W-1:0] addr,
	input wire logic [amp_pkg::DATA_W-1:0] dout,
	input wire logic dout_oe_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [3:0] slow,
	output logic ack,
	output logic [amp_pkg::DATA_W-1:0] pin
);
	import amp_pkg::*;
	logic [DATA_W-1:0] mem [16];
	logic [3:0] cnt_q;
	// ****
	// strobe service
	// ****
	always_ff @(posedge ref_clk)
	begin
		cnt_q <= (rd_n && wr_n) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
		if (!wr_n && !dout_oe_n)
			mem[addr[3:0]] <= dout;
	end
	assign ack = (rd_n && wr_n) || cnt_q >= slow;
	// pull-up level when nobody drives
	assign pin = !dout_oe_n ? dout : !rd_n ? mem[addr[3:0]] : 8'hFF;
endmodule

//--- sim/amp_port_tb.sv
// self-checking bench for the async memory port pins
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", nm, e, s); end end
module amp_port_tb;
	import amp_pkg::*;
	typedef struct packed {
		logic w, c, b;
		logic [3:0] slow;
		logic [23:0] a;
		logic [7:0] d, rd;
		logic [3:0] bs;
	} amp_row_s;
	logic ref_clk, rst, req_valid, req_write, req_cond, req_boot;
	logic wait_acknowledge, req_ready, rsp_valid, read_strobe_n;
	logic write_strobe_n, ext_addr_bus_oe_n, ext_data_bus_oe_n;
	logic [ADDR_W-1:0] req_addr, parallel_data_input, ext_addr_bus_out;
	logic [ADDR_W-1:0] ext_addr_bus_in, pdi_val;
	logic [DATA_W-1:0] req_wdata, data_alt_out, ext_data_bus_in, rsp_rdata;
	logic [DATA_W-1:0] data_alt_in, ext_data_bus_out;
	logic [1:0] addr_func, data_func, flag_bank_en, bank_select_n;
	logic [3:0] flag_out, flag_dir, flag_in, flag_level, flag_pin_out;
	logic [3:0] flag_pin_oe_n, slow;
	int fails, n_checks, cyc;
	amp_row_s rows [9] = '{
		'{1'h1, 1'h1, 1'h0, 4'h0, 24'h000005, 8'hA5, 8'h00, 4'hE},
		'{1'h1, 1'h1, 1'h0, 4'h3, 24'h400009, 8'h3C, 8'h00, 4'hD},
		'{1'h0, 1'h1, 1'h0, 4'h5, 24'h000005, 8'h00, 8'hA5, 4'hE},
		'{1'h0, 1'h1, 1'h0, 4'h0, 24'h400009, 8'h00, 8'h3C, 4'hD},
		'{1'h1, 1'h1, 1'h0, 4'h2, 24'h800002, 8'h5A, 8'h00, 4'hB},
		'{1'h0, 1'h1, 1'h0, 4'h0, 24'hC00002, 8'h00, 8'h5A, 4'h7},
		'{1'h0, 1'h1, 1'h1, 4'h0, 24'h000009, 8'h00, 8'h3C, 4'hD},
		'{1'h1, 1'h0, 1'h0, 4'h0, 24'h000005, 8'hFF, 8'h00, 4'hF},
		'{1'h0, 1'h1, 1'h0, 4'h0, 24'h000005, 8'h00, 8'hA5, 4'hE}};
	assign flag_in = flag_pin_out | flag_pin_oe_n;
	assign ext_addr_bus_in = ext_addr_bus_oe_n ? pdi_val : ext_addr_bus_out;
	amp_port dut (.ref_clk, .rst, .req_valid, .req_write, .req_cond,
		.req_boot, .req_addr, .req_wdata, .addr_func, .data_func,
		.flag_bank_en, .data_alt_out, .flag_out, .flag_dir,
		.wait_acknowledge, .ext_addr_bus_in, .ext_data_bus_in, .flag_in,
		.req_ready, .rsp_valid, .rsp_rdata, .parallel_data_input,
		.data_alt_in, .flag_level, .ext_addr_bus_out, .ext_addr_bus_oe_n,
		.ext_data_bus_out, .ext_data_bus_oe_n, .bank_select_n,
		.read_strobe_n, .write_strobe_n, .flag_pin_out, .flag_pin_oe_n);
	amp_mem_model mem (.ref_clk, .addr(ext_addr_bus_out),
		.dout(ext_data_bus_out), .dout_oe_n(ext_data_bus_oe_n),
		.rd_n(read_strobe_n), .wr_n(write_strobe_n), .slow,
		.ack(wait_acknowledge), .pin(ext_data_bus_in));
	// ****
	// tasks
	// ****
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk_idle;
		`CHK("sel", 4'hF, {flag_in[3:2], bank_select_n})
		`CHK("strobes", 2'h3, {read_strobe_n, write_strobe_n})
	endtask
	task automatic start(input amp_row_s r);
		for (int i = 0; i < 10 && req_ready !== 1'h1; i++)
			@(negedge ref_clk);
		{req_write, req_cond, req_boot} = {r.w, r.c, r.b};
		{req_addr, req_wdata, slow} = {r.a, r.d, r.slow};
		req_valid = 1'h1;
		@(negedge ref_clk);
		req_valid = 1'h0;
	endtask
	task automatic acc(input amp_row_s r);
		int n;
		n = 0;
		start(r);
		`CHK("sel", r.bs, {flag_in[3:2], bank_select_n})
		if (r.b)
			`CHK("boot", 2'h1, bank_select_n)
		if (r.c)
		begin
			`CHK("addr", r.a, ext_addr_bus_out)
			`CHK("rd", r.w, read_strobe_n)
			`CHK("wr", !r.w, write_strobe_n)
			if (r.w)
				`CHK("wdata", r.d, ext_data_bus_out)
		end
		while (rsp_valid !== 1'h1 && n < 40)
		begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("rsp", 1'h1, rsp_valid)
		if (r.c)
			`CHK("stretch", 1'h1, n >= int'(r.slow) + 3)
		if (r.c && !r.w)
			`CHK("rdata", r.rd, rsp_rdata)
		@(negedge ref_clk);
		chk_idle();
	endtask
	// ****
	// sequence
	// ****
	initial
	begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			test_done();
		end
	end
	initial
	begin
		{rst, req_valid, req_write, req_cond, req_boot} = 5'h10;
		{req_addr, req_wdata, addr_func, data_func} = '0;
		{data_alt_out, flag_out, flag_dir, slow, pdi_val} = '0;
		flag_bank_en = 2'h3;
		repeat (6) @(negedge ref_clk);
		chk_idle();
		`CHK("addr_oe", 1'h0, ext_addr_bus_oe_n)
		`CHK("flag_oe", 4'hF, flag_pin_oe_n)
		rst = 1'h0;
		foreach (rows[i])
			acc(rows[i]);
		addr_func = 2'h1;
		pdi_val = 24'h123456;
		{flag_dir, flag_out} = 8'h31;
		repeat (6) @(negedge ref_clk);
		`CHK("pdi", 24'h123456, parallel_data_input)
		`CHK("addr_oe", 1'h1, ext_addr_bus_oe_n)
		`CHK("flag_lvl", 4'hD, flag_level)
		addr_func = 2'h0;
		data_alt_out = 8'hC3;
		for (int f = 1; f < 4; f++)
		begin
			data_func = 2'(f);
			repeat (6) @(negedge ref_clk);
			`CHK("data_oe", f == 1, ext_data_bus_oe_n)
			`CHK("alt_in", f == 1 ? 8'hFF : 8'hC3, data_alt_in)
		end
		data_func = 2'h0;
		@(negedge ref_clk);
		`CHK("data_oe", 1'h1, ext_data_bus_oe_n)
		start(rows[2]);
		rst = 1'h1;
		@(negedge ref_clk);
		chk_idle();
		`CHK("ready", 2'h2, {req_ready, rsp_valid})
		`CHK("oe", 2'h1, {ext_addr_bus_oe_n, ext_data_bus_oe_n})
		rst = 1'h0;
		acc(rows[3]);
		test_done();
	end
endmodule
